/* hw/cfih_device.sv */
module cfih_device
   import cfih_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES = PULSE_CYC,
   parameter int unsigned PERIOD_CYCLES = PERIOD_CYC
)
(
   input wire logic clk_in,
   input wire logic rstn_in,
   cfih_if.dev bus,
   input wire logic wdt_expire_in,
   input wire logic startup_ok_in,
   input wire logic in_ovlo_in,
   input wire logic in_uvlo_in,
   input wire logic in_low_in,
   input wire logic bat_temp_out_in,
   input wire logic chip_temp_hi_in,
   input wire logic bat_ov_in,
   input wire logic bat_missing_in,
   input wire logic safety_timer_in,
   input wire logic in_vdrop_in,
   input wire logic in_overcur_in,
   input wire logic term_reached_in,
   input wire logic recharge_lvl_in,
   input wire logic fallback_in,
   input wire logic otg_overcur_in,
   input wire logic bat_uvlo_in,
   input wire logic otg_out_uvlo_in,
   output logic charge_on_out,
   output logic otg_on_out,
   output logic standby_out,
   output logic ilim_100ma_out,
   output logic cfg_reinit_out
);
   // true for registers that a watchdog expiry restores
   function automatic logic is_cfg(input logic [7:0] a);
      is_cfg = (a <= REG_CFG_LAST) || (a == REG_CFG_1E) || (a == REG_CFG_1F);
   endfunction

   logic [7:0] cfg [0:31];
   logic [7:0] stat_ctrl;
   logic [NFACT-1:0] factor;
   logic [NFACT-1:0] mask;
   logic [16:0] ev_q;
   logic chg_hold;
   logic otg_hold;
   logic ilim;
   logic [31:0] per_cnt;
   cfih_mode_t mode;
   cfih_mode_t next_mode;

   ////////////////////////////////////////////////////////////////////////////
   // event edges: detectors give levels, a flag is raised only on onset, save the recharge flag, which reads the level
   wire logic [16:0] ev = {wdt_expire_in, in_ovlo_in, in_uvlo_in, in_low_in, bat_temp_out_in, chip_temp_hi_in,
                           bat_ov_in, bat_missing_in, safety_timer_in, in_vdrop_in, in_overcur_in,
                           term_reached_in, recharge_lvl_in, fallback_in, otg_overcur_in, bat_uvlo_in,
                           otg_out_uvlo_in};
   wire logic [16:0] r = ev & ~ev_q;
   wire logic r_wdt = r[16];
   wire logic r_ovlo = r[15];
   wire logic r_low = r[13];
   wire logic r_btemp = r[12];
   wire logic r_chip = r[11];
   wire logic r_battery_overvoltage_flag = r[10];
   wire logic r_miss = r[9];
   wire logic r_tmr = r[8];
   wire logic r_vdrop = r[7];
   wire logic r_ocur = r[6];
   wire logic r_term = r[5];
   wire logic r_fallbk = r[3];
   wire logic r_otgf = r[2] | r[1] | r[0] | (r_chip && mode == M_OTG);

   ////////////////////////////////////////////////////////////////////////////
   // register decode
   wire logic [7:0] susp_cfg = cfg[REG_SUSP_CFG[4:0]];
   wire logic batt_susp = susp_cfg[BIT_BATT_SUSP];
   wire logic chip_susp = susp_cfg[BIT_CHIP_SUSP];
   wire logic auto_rechg_off = susp_cfg[BIT_AUTO_RECHG];
   wire logic ailim_off = cfg[REG_ILIM_CFG[4:0]][BIT_AUTO_ILIM];
   wire logic w_cfg = bus.reg_wr && is_cfg(bus.reg_addr);
   wire logic w_stat = bus.reg_wr && bus.reg_addr == REG_STAT_CTRL;
   wire logic w_fact = bus.reg_wr && bus.reg_addr == REG_FACTOR;
   wire logic w_mask = bus.reg_wr && bus.reg_addr == REG_MASK;
   wire logic [NFACT-1:0] clr = w_fact ? bus.reg_wdata[NFACT-1:0] : '0;
   wire logic wdt_act = r_wdt && mode != M_DONE; // watchdogs are idle between completion and recharge
   wire logic [7:0] info_a = {bat_missing_in, bat_ov_in, 3'h0, chip_temp_hi_in, bat_temp_out_in, 1'b0};
   wire logic [7:0] info_b = {3'h0, otg_out_uvlo_in, chip_temp_hi_in && mode == M_OTG, otg_hold,
                              otg_overcur_in, bat_uvlo_in};
   wire logic [7:0] info_c = {ilim, chg_hold, 2'h0, mode};
   wire logic [7:0] rd_val = is_cfg(bus.reg_addr) ? cfg[bus.reg_addr[4:0]] :
                             (bus.reg_addr == REG_STAT_CTRL) ? stat_ctrl :
                             (bus.reg_addr == REG_FACTOR) ? {1'b0, factor} :
                             (bus.reg_addr == REG_INFO_A) ? info_a :
                             (bus.reg_addr == REG_INFO_B) ? info_b :
                             (bus.reg_addr == REG_INFO_C) ? info_c :
                             (bus.reg_addr == REG_MASK) ? {1'b0, mask} : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // charge stops
   wire logic in_fault = in_ovlo_in | in_uvlo_in | in_low_in;
   wire logic temp_stop = (bat_temp_out_in && batt_susp) || (chip_temp_hi_in && chip_susp);
   wire logic chg_block = in_fault | temp_stop | chg_hold;
   wire logic set_chg_hold = r_battery_overvoltage_flag | r_miss | r_tmr;
   wire logic otg_fault = r_otgf | (wdt_act && mode == M_OTG);
   wire logic set_ilim = (r_vdrop && !ailim_off) || r_ocur;
   wire logic do_rechg = mode == M_DONE && bus.chg_en && recharge_lvl_in && !auto_rechg_off;

   // mode sequencing; a watchdog in charge leaves charging alone
   always_comb begin
      next_mode = mode;
      unique case (mode)
         M_STBY: begin
            if (bus.chg_en && startup_ok_in && !chg_block && !set_chg_hold) next_mode = M_CHG;
            else if (bus.otg_en && !otg_hold && !otg_fault) next_mode = M_OTG;
         end
         M_CHG: begin
            if (!bus.chg_en || chg_block || set_chg_hold) next_mode = M_STBY;
            else if (r_term) next_mode = M_DONE;
         end
         M_DONE: begin
            if (!bus.chg_en || in_fault) next_mode = M_STBY;
            else if (do_rechg) next_mode = M_CHG;
         end
         M_OTG: begin
            if (otg_fault || !bus.otg_en) next_mode = M_STBY;
         end
         default: next_mode = M_STBY;
      endcase
   end

   // factor sources; an input undervoltage onset raises nothing
   wire logic [NFACT-1:0] set_f;
   assign set_f[F_STBWDT] = wdt_act && mode == M_STBY;
   assign set_f[F_CHGERR] = r_ovlo | r_low | r_btemp | (r_chip && mode != M_OTG) | set_chg_hold |
                            (r_vdrop && !ailim_off) | (wdt_act && mode == M_CHG);
   assign set_f[F_RECHG] = do_rechg && next_mode == M_CHG;
   assign set_f[F_OTGERR] = mode == M_OTG && otg_fault;
   assign set_f[F_DONE] = mode == M_CHG && next_mode == M_DONE;
   assign set_f[F_ILIM] = r_ocur;
   assign set_f[F_FALLBK] = r_fallbk;
   wire logic [NFACT-1:0] next_factor = set_f | (factor & ~clr); // set wins over clear
   wire logic pending = |(next_factor & ~mask);

   ////////////////////////////////////////////////////////////////////////////
   // status pin drive: low while charging or input out of range, or pulsed on interrupt
   wire logic state_low = next_mode == M_CHG || in_uvlo_in || in_ovlo_in;
   wire logic int_low = pending && per_cnt < PULSE_CYCLES;
   wire logic next_stat_oe = stat_ctrl[BIT_PIN_ON] && (stat_ctrl[BIT_INFO_SEL] ? int_low : state_low);
   wire logic [31:0] next_per = (!pending || per_cnt >= PERIOD_CYCLES - 1) ? 32'h0 : per_cnt + 32'h1;

   // configuration array: watchdog reload wins over a write in the same cycle
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < 32; i++) cfg[i] <= CFG_RST;
      end else begin
         for (int i = 0; i < 32; i++) begin
            if (wdt_act && is_cfg(8'(i))) cfg[i] <= CFG_RST;
            else if (w_cfg && bus.reg_addr[4:0] == 5'(i)) cfg[i] <= bus.reg_wdata;
         end
      end
   end

   // control and flags
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stat_ctrl <= STAT_CTRL_RST;
         mask <= MASK_RST[NFACT-1:0];
         factor <= '0;
         ev_q <= '0;
         mode <= M_STBY;
         chg_hold <= 1'b0;
         otg_hold <= 1'b0;
         ilim <= 1'b0;
         per_cnt <= 32'h0;
      end else begin
         if (w_stat) stat_ctrl <= bus.reg_wdata;
         if (w_mask) mask <= bus.reg_wdata[NFACT-1:0];
         factor <= next_factor;
         ev_q <= ev;
         mode <= next_mode;
         chg_hold <= set_chg_hold || (chg_hold && bus.chg_en); // released by enable low
         otg_hold <= otg_fault || (otg_hold && bus.otg_en);
         ilim <= set_ilim || (ilim && !(clr[F_ILIM] || clr[F_CHGERR]));
         per_cnt <= next_per;
      end
   end

   // outputs, all registered
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bus.reg_rdata <= 8'h00;
         bus.stat_o <= 1'b0;
         bus.stat_oe <= 1'b0;
         charge_on_out <= 1'b0;
         otg_on_out <= 1'b0;
         standby_out <= 1'b1;
         ilim_100ma_out <= 1'b0;
         cfg_reinit_out <= 1'b0;
      end else begin
         bus.reg_rdata <= bus.reg_rd ? rd_val : 8'h00;
         bus.stat_oe <= next_stat_oe;
         charge_on_out <= next_mode == M_CHG;
         otg_on_out <= next_mode == M_OTG;
         standby_out <= next_mode == M_STBY;
         ilim_100ma_out <= set_ilim || (ilim && !(clr[F_ILIM] || clr[F_CHGERR]));
         cfg_reinit_out <= wdt_act;
      end
   end
endmodule

/* hw/cfih_host.sv */
// host end: software orders the device through a small mailbox
module cfih_host
   import cfih_pkg::*;
(
   input wire logic clk_in,
   input wire logic rstn_in,
   cfih_if.host bus,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   output logic irq_out
);
   logic [1:0] ctrl;
   logic [7:0] daddr;
   logic [7:0] drdata;
   logic [1:0] status;
   logic [1:0] enable;
   logic rd_q;
   logic stat_s1;
   logic stat_s2;
   logic stat_s3;

   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire logic w_ctrl = wr_in && addr_in == H_CTRL;
   wire logic w_daddr = wr_in && addr_in == H_DADDR;
   wire logic w_dwdata = wr_in && addr_in == H_DWDATA;
   wire logic w_drd = wr_in && addr_in == H_DRD;
   wire logic w_clear = wr_in && addr_in == H_CLEAR;
   wire logic w_enable = wr_in && addr_in == H_ENABLE;
   wire logic stat_fall = stat_s3 && !stat_s2; // pulse or change to the low state seen on the pin
   wire logic [1:0] ev = {rd_q, stat_fall};
   wire logic [1:0] next_status = ev | (status & ~(w_clear ? wdata_in[1:0] : 2'h0)); // set wins
   wire logic [7:0] rd_val = (addr_in == H_CTRL) ? {6'h0, ctrl} :
                             (addr_in == H_DADDR) ? daddr :
                             (addr_in == H_DRDATA) ? drdata :
                             (addr_in == H_STATUS) ? {6'h0, status} :
                             (addr_in == H_ENABLE) ? {6'h0, enable} : 8'h00;

   // pin synchroniser: the first stage feeds only the second
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stat_s1 <= 1'b1;
         stat_s2 <= 1'b1;
         stat_s3 <= 1'b1;
      end else begin
         stat_s1 <= bus.stat_line;
         stat_s2 <= stat_s1;
         stat_s3 <= stat_s2;
      end
   end

   // local registers; enables drive the pins, so recovery toggles go through ctrl
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl <= HCTRL_RST;
         daddr <= 8'h00;
         enable <= 2'h0;
         status <= 2'h0;
      end else begin
         if (w_ctrl) ctrl <= wdata_in[1:0];
         if (w_daddr) daddr <= wdata_in;
         if (w_enable) enable <= wdata_in[1:0];
         status <= next_status;
      end
   end

   // device access: one strobe per mailbox write, data captured the cycle after a read
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bus.reg_addr <= 8'h00;
         bus.reg_wdata <= 8'h00;
         bus.reg_wr <= 1'b0;
         bus.reg_rd <= 1'b0;
         rd_q <= 1'b0;
         drdata <= 8'h00;
      end else begin
         bus.reg_wr <= w_dwdata;
         bus.reg_rd <= w_drd;
         if (w_dwdata || w_drd) bus.reg_addr <= daddr;
         if (w_dwdata) bus.reg_wdata <= wdata_in;
         rd_q <= bus.reg_rd;
         if (rd_q) drdata <= bus.reg_rdata;
      end
   end

   // outputs
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_out <= 8'h00;
         irq_out <= 1'b0;
         bus.chg_en <= 1'b0;
         bus.otg_en <= 1'b0;
      end else begin
         rdata_out <= rd_in ? rd_val : 8'h00;
         irq_out <= |(next_status & enable);
         bus.chg_en <= w_ctrl ? wdata_in[HB_CHG_EN] : ctrl[HB_CHG_EN];
         bus.otg_en <= w_ctrl ? wdata_in[HB_OTG_EN] : ctrl[HB_OTG_EN];
      end
   end
endmodule

/* inc/cfih_if.sv */
interface cfih_if;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_wr;
   logic reg_rd;
   logic chg_en;
   logic otg_en;
   logic stat_o;
   logic stat_oe;
   logic stat_line;

   // open-drain status pin with pull-up
   assign stat_line = stat_oe ? stat_o : 1'b1;

   modport dev (input reg_addr, input reg_wdata, input reg_wr, input reg_rd, input chg_en, input otg_en,
                output reg_rdata, output stat_o, output stat_oe);
   modport host (output reg_addr, output reg_wdata, output reg_wr, output reg_rd, output chg_en,
                 output otg_en, input reg_rdata, input stat_line);
endinterface

/* inc/cfih_pkg.sv */
package cfih_pkg;
   // clock and status pin timing
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam real PULSE_MS = 0.8;
   localparam real PERIOD_MS = 350.0;
   localparam int unsigned PULSE_CYC = int'($floor(PULSE_MS * real'(CLK_HZ) / 1000.0));
   localparam int unsigned PERIOD_CYC = int'($floor(PERIOD_MS * real'(CLK_HZ) / 1000.0));

   ////////////////////////////////////////////////////////////////////////////
   // device register map
   localparam logic [7:0] REG_CFG_LAST = 8'h13;
   localparam logic [7:0] REG_CFG_1E = 8'h1E;
   localparam logic [7:0] REG_CFG_1F = 8'h1F;
   localparam logic [7:0] REG_STAT_CTRL = 8'h14;
   localparam logic [7:0] REG_FACTOR = 8'h20;
   localparam logic [7:0] REG_INFO_A = 8'h21;
   localparam logic [7:0] REG_INFO_B = 8'h22;
   localparam logic [7:0] REG_INFO_C = 8'h23;
   localparam logic [7:0] REG_MASK = 8'h24;
   localparam logic [7:0] REG_SUSP_CFG = 8'h12;
   localparam logic [7:0] REG_ILIM_CFG = 8'h13;

   // field positions
   localparam int unsigned BIT_BATT_SUSP = 7;
   localparam int unsigned BIT_CHIP_SUSP = 6;
   localparam int unsigned BIT_AUTO_RECHG = 4;
   localparam int unsigned BIT_AUTO_ILIM = 0;
   localparam int unsigned BIT_INFO_SEL = 3;
   localparam int unsigned BIT_PIN_ON = 1;
   localparam int unsigned F_STBWDT = 0;
   localparam int unsigned F_CHGERR = 1;
   localparam int unsigned F_RECHG = 2;
   localparam int unsigned F_OTGERR = 3;
   localparam int unsigned F_DONE = 4;
   localparam int unsigned F_ILIM = 5;
   localparam int unsigned F_FALLBK = 6;
   localparam int unsigned NFACT = 7;

   // reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] STAT_CTRL_RST = 8'h02;
   localparam logic [7:0] MASK_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // host register map
   localparam logic [3:0] H_CTRL = 4'h0;
   localparam logic [3:0] H_DADDR = 4'h1;
   localparam logic [3:0] H_DWDATA = 4'h2;
   localparam logic [3:0] H_DRD = 4'h3;
   localparam logic [3:0] H_DRDATA = 4'h4;
   localparam logic [3:0] H_STATUS = 4'h5;
   localparam logic [3:0] H_CLEAR = 4'h6;
   localparam logic [3:0] H_ENABLE = 4'h7;
   localparam int unsigned HB_CHG_EN = 0;
   localparam int unsigned HB_OTG_EN = 1;
   localparam int unsigned HE_STAT = 0;
   localparam int unsigned HE_RDONE = 1;
   localparam logic [1:0] HCTRL_RST = 2'h0;

   // operating modes
   typedef enum logic [3:0] {
      M_STBY = 4'h1,
      M_CHG = 4'h2,
      M_DONE = 4'h4,
      M_OTG = 4'h8
   } cfih_mode_t;
endpackage

/* tb/cfih_asserts.sv */
module cfih_asserts
   import cfih_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES = 4
)
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic stat_o,
   input wire logic stat_oe
);
   logic [7:0] ctl;
   logic [7:0] next_ctl;
   int unsigned run;
   int unsigned next_run;

   ////////////////////////////////////////////////////////////////////////////
   // shadow of the pin control register and length of the current low stretch
   assign next_ctl = (reg_wr && reg_addr == REG_STAT_CTRL) ? reg_wdata : ctl;
   assign next_run = stat_oe ? run + 1 : 0;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctl <= STAT_CTRL_RST;
         run <= 0;
      end else begin
         ctl <= next_ctl;
         run <= next_run;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // one clock domain, so clock and reset are given once
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not idle");
   chk_ctl_readback: assert property (reg_rd && reg_addr == REG_STAT_CTRL |=>
      reg_rdata[BIT_INFO_SEL] == ctl[BIT_INFO_SEL] && reg_rdata[BIT_PIN_ON] == ctl[BIT_PIN_ON])
      else $error("pin control readback differs");
   chk_factor_width: assert property (reg_rd && reg_addr == REG_FACTOR |=> !reg_rdata[7])
      else $error("unused factor bit set");
   chk_unmapped_zero: assert property (reg_rd && (reg_addr > REG_MASK ||
      (reg_addr > REG_STAT_CTRL && reg_addr < REG_CFG_1E)) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_drive_low: assert property (stat_o == 1'b0)
      else $error("pin driven high");
   // a switch-off lands one cycle after the write, hence two cycles of off
   chk_pin_off: assert property (!ctl[BIT_PIN_ON] && !$past(ctl[BIT_PIN_ON]) |-> !stat_oe)
      else $error("pin driven while off");
   chk_pulse_len: assert property (ctl[BIT_INFO_SEL] && $past(ctl[BIT_INFO_SEL]) && stat_oe |->
      run < PULSE_CYCLES)
      else $error("pulse too long");
   chk_strobe_excl: assert property (!(reg_wr && reg_rd))
      else $error("both strobes high");

   cover property (ctl[BIT_INFO_SEL] && $rose(stat_oe));
   cover property (reg_rd && reg_addr == REG_FACTOR);
   cover property (!ctl[BIT_PIN_ON] ##1 !ctl[BIT_PIN_ON]);
endmodule

/* tb/charger_fault_interrupt_handler_test.sv */
module charger_fault_interrupt_handler_test
   import cfih_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PU = 4;
   localparam int PE = 20;
   logic clk_in = 0;
   logic rstn_in = 0;
   logic [3:0] addr_in = '0;
   logic [7:0] wdata_in = '0;
   logic wr_in = 0;
   logic rd_in = 0;
   logic [16:0] ev = '0;
   logic startup_ok_in = 1;
   logic [7:0] rdata_out, d, r;
   logic [7:0] ca [4];
   logic irq_out;
   logic [4:0] o;
   int n_errors = 0;
   int samples_checked = 0;
   int n_reinit = 0;
   int lo, gap, c, i, s, j;
   int s_in[2] = '{1, 3};
   int s_bat[3] = '{6, 7, 8};
   int s_otg[4] = '{14, 15, 16, 5};

   ////////////////////////////////////////////////////////////////////////////
   cfih_if bif();
   cfih_device #(.PULSE_CYCLES(PU), .PERIOD_CYCLES(PE)) u_cfih_device (.clk_in, .rstn_in, .bus(bif.dev),
      .wdt_expire_in(ev[0]), .startup_ok_in, .in_ovlo_in(ev[1]), .in_uvlo_in(ev[2]), .in_low_in(ev[3]),
      .bat_temp_out_in(ev[4]), .chip_temp_hi_in(ev[5]), .bat_ov_in(ev[6]), .bat_missing_in(ev[7]),
      .safety_timer_in(ev[8]), .in_vdrop_in(ev[9]), .in_overcur_in(ev[10]), .term_reached_in(ev[11]),
      .recharge_lvl_in(ev[12]), .fallback_in(ev[13]), .otg_overcur_in(ev[14]), .bat_uvlo_in(ev[15]),
      .otg_out_uvlo_in(ev[16]), .charge_on_out(o[0]), .otg_on_out(o[1]), .standby_out(o[2]),
      .ilim_100ma_out(o[3]), .cfg_reinit_out(o[4]));
   cfih_host u_cfih_host (.clk_in, .rstn_in, .bus(bif.host), .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .irq_out);
   cfih_asserts #(.PULSE_CYCLES(PU)) u_cfih_asserts (.clk_in, .rstn_in, .reg_addr(bif.reg_addr),
      .reg_wdata(bif.reg_wdata), .reg_rdata(bif.reg_rdata), .reg_wr(bif.reg_wr), .reg_rd(bif.reg_rd),
      .stat_o(bif.stat_o), .stat_oe(bif.stat_oe));

   // 50 MHz clock and a count of config reload pulses
   initial begin
      forever #10 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (o[4] === 1'b1) n_reinit++;
   end

   ////////////////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task chk(string n, logic [7:0] seen, logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", n, exp, seen);
         n_errors++;
      end
   endtask
   function logic [7:0] fl(int b);
      return 8'h01 << b;
   endfunction
   task tick(int n);
      repeat (n) @(posedge clk_in);
   endtask
   // host port cycles: one-cycle strobes, read data taken in the cycle after
   task hw(logic [3:0] a, logic [7:0] v);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task hr(logic [3:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      d = rdata_out;
   endtask
   task dw(logic [7:0] a, logic [7:0] v);
      hw(H_DADDR, a);
      hw(H_DWDATA, v);
   endtask
   // device read through the mailbox; data lands three cycles after the trigger
   task dchk(string n, logic [7:0] a, logic [7:0] e);
      hw(H_DADDR, a);
      hw(H_DRD, 8'h00);
      tick(3);
      hr(H_DRDATA);
      chk(n, d, e);
   endtask
   // bounded wait on a device output; running out ends the run
   task wt(int k0, logic v);
      int k;
      for (k = 0; k < 50 && o[k0] !== v; k++) begin
         tick(1);
      end
      chk("device output", {7'h00, o[k0]}, {7'h00, v});
      if (k == 50) end_of_test;
   endtask
   task fire(int k0);
      @(posedge clk_in);
      ev[k0] <= 1'b1;
      tick(2);
      ev[k0] <= 1'b0;
   endtask
   task lows;
      c = 0;
      repeat (PE) begin
         @(negedge clk_in);
         if (bif.stat_line !== 1'b1) c++;
      end
   endtask
   // bounded wait for a pin level; running out ends the run
   task wl(logic v);
      for (j = 0; j < 60 && bif.stat_line !== v; j++) @(negedge clk_in);
      if (j == 60) begin
         n_errors++;
         end_of_test;
      end
   endtask
   // the first pulse may be cut short by the switch-on, so a whole one is measured
   task pin;
      lo = 0;
      gap = 0;
      wl(1'b0);
      wl(1'b1);
      wl(1'b0);
      while (bif.stat_line === 1'b0 && lo < 60) begin
         lo++;
         gap++;
         @(negedge clk_in);
      end
      while (bif.stat_line === 1'b1 && gap < 60) begin
         gap++;
         @(negedge clk_in);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hb9ff0cb4));
      tick(4);
      rstn_in <= 1'b1;
      wt(2, 1'b1);
      chk("irq", {7'h00, irq_out}, 8'h00);
      dchk("pin ctrl", REG_STAT_CTRL, STAT_CTRL_RST);
      dchk("mask", REG_MASK, MASK_RST);
      dchk("unmapped", 8'h30, 8'h00);
      // random config contents, then the standby watchdog wipes them
      for (i = 0; i < 4; i++) begin
         ca[i] = (i == 3) ? REG_CFG_1F : 8'($urandom_range(0, 17));
         r = 8'($urandom_range(1, 255));
         dw(ca[i], r);
         dchk("cfg", ca[i], r);
      end
      fire(0);
      wt(2, 1'b1);
      dchk("factor", REG_FACTOR, fl(F_STBWDT));
      for (i = 0; i < 4; i++) dchk("cfg", ca[i], CFG_RST);
      chk("reloads", 8'(n_reinit), 8'h01);
      // software restores a wiped register
      dw(ca[0], r);
      dchk("cfg", ca[0], r);
      // pending flag pulses the pin; mask and switch-off silence it
      hw(H_ENABLE, 8'h01);
      dw(REG_STAT_CTRL, 8'h0A);
      pin();
      chk("pulse", 8'(lo), 8'(PU));
      chk("period", 8'(gap), 8'(PE));
      chk("irq", {7'h00, irq_out}, 8'h01);
      dw(REG_MASK, 8'h7F);
      tick(PU + 2);
      lows();
      chk("masked lows", 8'(c), 8'h00);
      dw(REG_MASK, MASK_RST);
      tick(2);
      lows();
      chk("lows", 8'(c), 8'(PU));
      dw(REG_STAT_CTRL, 8'h08);
      tick(2);
      lows();
      chk("off lows", 8'(c), 8'h00);
      dw(REG_FACTOR, 8'h7F);
      dchk("factor", REG_FACTOR, 8'h00);
      hw(H_CLEAR, 8'h03);
      tick(2);
      chk("irq", {7'h00, irq_out}, 8'h00);
      dw(REG_STAT_CTRL, STAT_CTRL_RST);
      // charging in state mode holds the pin low
      hw(H_CTRL, 8'h01);
      wt(0, 1'b1);
      tick(2);
      lows();
      chk("state lows", 8'(c), 8'(PE));
      foreach (s_in[k]) begin
         @(posedge clk_in) ev[s_in[k]] <= 1'b1;
         wt(0, 1'b0);
         @(posedge clk_in) ev[s_in[k]] <= 1'b0;
         wt(0, 1'b1);
         dchk("factor", REG_FACTOR, fl(F_CHGERR));
         dw(REG_FACTOR, 8'h7F);
      end
      @(posedge clk_in) ev[2] <= 1'b1;
      wt(0, 1'b0);
      @(posedge clk_in) ev[2] <= 1'b0;
      wt(0, 1'b1);
      dchk("factor", REG_FACTOR, 8'h00);
      // temperature faults: suspend only when the matching bit is set
      for (i = 0; i < 4; i++) begin
         s = 4 + i % 2;
         dw(REG_SUSP_CFG, (i < 2) ? 8'h00 : fl(BIT_BATT_SUSP + 4 - s));
         @(posedge clk_in) ev[s] <= 1'b1;
         tick(4);
         wt(0, i < 2);
         @(posedge clk_in) ev[s] <= 1'b0;
         wt(0, 1'b1);
         dchk("factor", REG_FACTOR, fl(F_CHGERR));
         dw(REG_FACTOR, 8'h7F);
      end
      foreach (s_bat[k]) begin
         fire(s_bat[k]);
         wt(0, 1'b0);
         tick(5);
         wt(0, 1'b0);
         hw(H_CTRL, 8'h00);
         hw(H_CTRL, 8'h01);
         wt(0, 1'b1);
         dw(REG_FACTOR, 8'h7F);
      end
      // input limit holds until the factor is cleared
      for (i = 9; i < 11; i++) begin
         fire(i);
         wt(3, 1'b1);
         tick(4);
         wt(3, 1'b1);
         wt(0, 1'b1);
         dw(REG_FACTOR, 8'h7F);
         wt(3, 1'b0);
      end
      fire(13);
      dchk("factor", REG_FACTOR, fl(F_FALLBK));
      wt(0, 1'b1);
      dw(REG_FACTOR, 8'h7F);
      fire(0);
      tick(3);
      wt(0, 1'b1);
      chk("reloads", 8'(n_reinit), 8'h02);
      dchk("factor", REG_FACTOR, fl(F_CHGERR));
      dw(REG_FACTOR, 8'h7F);
      fire(11);
      wt(0, 1'b0);
      fire(12);
      wt(0, 1'b1);
      dchk("factor", REG_FACTOR, fl(F_DONE) | fl(F_RECHG));
      dw(REG_FACTOR, 8'h7F);
      // reverse supply faults need an enable toggle
      hw(H_CTRL, 8'h00);
      wt(0, 1'b0);
      hw(H_CTRL, 8'h02);
      wt(1, 1'b1);
      foreach (s_otg[k]) begin
         fire(s_otg[k]);
         wt(1, 1'b0);
         dchk("factor", REG_FACTOR, fl(F_OTGERR));
         dw(REG_FACTOR, 8'h7F);
         hw(H_CTRL, 8'h00);
         hw(H_CTRL, 8'h02);
         wt(1, 1'b1);
      end
      fire(0);
      wt(1, 1'b0);
      wt(2, 1'b1);
      dchk("factor", REG_FACTOR, fl(F_OTGERR));
      chk("reloads", 8'(n_reinit), 8'h03);
      end_of_test;
   end
endmodule
